// >>> design/drit_defines.vh
/*
  Constants of the DRAM refresh interval timer: register byte offsets,
  field positions, reset values and prescaler tap positions.
  Assumes inclusion by bare name from the design files.
*/
`ifndef DRIT_DEFINES_VH
`define DRIT_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets and the word index of the last register
// ----------------------------------------------------------------------
`define DRIT_OFS_COUNTER   8'h00
`define DRIT_OFS_COMPARE   8'h04
`define DRIT_OFS_CONTROL   8'h08
`define DRIT_OFS_STATUS    8'h0C
`define DRIT_OFS_MASK      8'h10
`define DRIT_LAST_INDEX    6'h04

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DRIT_CTL_SEL_LSB   0
`define DRIT_CTL_SEL_MSB   2
`define DRIT_CTL_RFSH_BIT  3
`define DRIT_STAT_MATCH    0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DRIT_RST_COUNTER   8'h00
`define DRIT_RST_COMPARE   8'hFF
`define DRIT_RST_SEL       3'h0

// ----------------------------------------------------------------------
// Prescaler taps: divide by 2 to the tap plus one
// ----------------------------------------------------------------------
`define DRIT_TAP_1         4'h0
`define DRIT_TAP_2         4'h2
`define DRIT_TAP_3         4'h4
`define DRIT_TAP_4         4'h6
`define DRIT_TAP_5         4'h8
`define DRIT_TAP_6         4'hA
`define DRIT_TAP_7         4'hB

// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define DRIT_RESP_OKAY     2'h0
`define DRIT_RESP_SLVERR   2'h2

`endif

// >>> design/drit_prescaler.v
/*
  Prescaler of the refresh timer: a free divider whose selected tap
  yields a one-cycle count tick.
  Assumes aclk, synchronous active-low reset and a clock enable.
*/
`timescale 1ns/1ps
`include "drit_defines.vh"

module drit_prescaler (
  // Clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       ce,
  // Control
  input  wire       run,
  input  wire [2:0] select,
  // Tick
  output wire       tick
);

  reg  [11:0] div;
  reg  [3:0]  tap;
  wire [11:0] next_div;

  assign next_div = div + 12'h001;

  always @(posedge aclk) begin
    if (!aresetn) begin
      div <= 12'h000;
    end else if (ce) begin
      if (run) begin
        div <= next_div;
      end
    end
  end

  always @* begin
    case (select)
      3'h1:    tap = `DRIT_TAP_1;
      3'h2:    tap = `DRIT_TAP_2;
      3'h3:    tap = `DRIT_TAP_3;
      3'h4:    tap = `DRIT_TAP_4;
      3'h5:    tap = `DRIT_TAP_5;
      3'h6:    tap = `DRIT_TAP_6;
      default: tap = `DRIT_TAP_7;
    endcase
  end

  // A tick marks the selected bit about to fall, so the tick rate is
  // the divided clock rate and select zero stops counting.
  assign tick = ce & run & (select != 3'h0) & div[tap] & ~next_div[tap];

endmodule // drit_prescaler

// >>> design/drit_axil_slave.v
/*
  AXI4-Lite slave front end of the refresh timer. Turns bus traffic
  into a write strobe and a read address, and answers unmapped or
  misaligned addresses with SLVERR.
  Assumes one clock, synchronous active-low reset, a clock enable,
  and read data from the owner decoded combinationally from rd_addr.
*/
`timescale 1ns/1ps
`include "drit_defines.vh"

module drit_axil_slave (
  // Clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       ce,
  // Write address and data
  input  wire [7:0] s_axi_awaddr,
  input  wire       s_axi_awvalid,
  output reg        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0] s_axi_wstrb,
  input  wire       s_axi_wvalid,
  output reg        s_axi_wready,
  // Write response
  output reg  [1:0] s_axi_bresp,
  output reg        s_axi_bvalid,
  input  wire       s_axi_bready,
  // Read
  input  wire [7:0] s_axi_araddr,
  input  wire       s_axi_arvalid,
  output reg        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0] s_axi_rresp,
  output reg        s_axi_rvalid,
  input  wire       s_axi_rready,
  // Register side
  output wire       wr_en,
  output reg  [7:0] wr_addr,
  output reg  [7:0] wr_data,
  output reg        wr_lane0,
  output wire [7:0] rd_addr,
  input  wire [7:0] rd_data
);

  wire wr_fire;
  wire wr_ok;
  wire rd_ok;

  assign wr_ok   = (wr_addr[1:0] == 2'h0) &&
                   (wr_addr[7:2] <= `DRIT_LAST_INDEX);
  assign rd_ok   = (s_axi_araddr[1:0] == 2'h0) &&
                   (s_axi_araddr[7:2] <= `DRIT_LAST_INDEX);
  assign rd_addr = s_axi_araddr;

  // Both halves held and no answer pending.
  assign wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wr_en   = ce & wr_fire & wr_ok;

  // ----------------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DRIT_RESP_OKAY;
      wr_addr       <= 8'h00;
      wr_data       <= 8'h00;
      wr_lane0      <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_data      <= s_axi_wdata[7:0];
        wr_lane0     <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `DRIT_RESP_OKAY : `DRIT_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read channels
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `DRIT_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rd_ok ? rd_data : 8'h00};
        s_axi_rresp   <= rd_ok ? `DRIT_RESP_OKAY : `DRIT_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // drit_axil_slave

// >>> design/drit_timer.v
/*
  DRAM refresh interval timer: 8-bit up-counter on a prescaled tick,
  compared with an 8-bit compare value; a match sets a sticky flag,
  clears the counter, requests a refresh cycle and may interrupt.
  Assumes an AXI4-Lite master, standby pins from another clock domain
  and refresh cycle logic on aclk answering with refresh_ack.
*/
// Function
// RL1: Refresh counter is an 8-bit up-counter, readable and writable anytime.
// RL2: Counter advances on prescaled tick chosen by three-bit select field.
// RL3: Counter equal to compare value sets match flag and clears counter.
// RL4: Match with refresh enable set starts a DRAM refresh cycle.
// RL5: Match with interrupt enable set also raises compare-match interrupt.
// RL6: Counter zeroed by power-on reset, hardware standby; kept otherwise.
// RL7: Compare register is 8-bit read/write and sets match period.
// RL8: Compare register all ones after power-on reset, hardware standby.
// RL9: Match flag stays set until software clears it.
`timescale 1ns/1ps
`include "drit_defines.vh"

module drit_timer (
  // Clock, reset and clock enable
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  // Standby pins
  input  wire        hw_standby,
  input  wire        sw_standby,
  // AXI4-Lite write
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Refresh cycle logic
  output reg         refresh_req,
  input  wire        refresh_ack,
  // Interrupt
  output reg         match_interrupt
);

  // ----------------------------------------------------------------------
  // Standby synchronisers
  // ----------------------------------------------------------------------
  reg  [1:0] hw_sync;
  reg  [1:0] sw_sync;
  wire       hw_stby;
  wire       sw_stby;

  always @(posedge aclk) begin
    if (!aresetn) begin
      hw_sync <= 2'h0;
      sw_sync <= 2'h0;
    end else if (ce) begin
      hw_sync <= {hw_sync[0], hw_standby};
      sw_sync <= {sw_sync[0], sw_standby};
    end
  end

  assign hw_stby = hw_sync[1];
  assign sw_stby = sw_sync[1];

  // ----------------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------------
  wire       wr_en;
  wire [7:0] wr_addr;
  wire [7:0] wr_data;
  wire       wr_lane0;
  wire [7:0] rd_addr;
  reg  [7:0] rd_data;
  wire       wr_byte;

  drit_axil_slave u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .ce            (ce),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_lane0      (wr_lane0),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data)
  );

  assign wr_byte = wr_en & wr_lane0;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg  [7:0] refresh_counter;
  reg  [7:0] refresh_compare_value;
  reg  [2:0] prescale_select_field;
  reg        refresh_enable_bit;
  reg        match_flag;
  reg        match_irq_enable;
  wire       tick;
  wire       match;
  wire       flag_clear;

  // Counting stops in software standby while the counter keeps its value.
  drit_prescaler u_presc (
    .aclk    (aclk),
    .aresetn (aresetn & ~hw_stby),
    .ce      (ce),
    .run     (~sw_stby),
    .select  (prescale_select_field),
    .tick    (tick)
  );

  // Equality is judged at the tick so one period is compare plus one
  // ticks and a compare of zero does not match on every clock.
  assign match      = tick & (refresh_counter == refresh_compare_value);
  assign flag_clear = wr_byte && (wr_addr == `DRIT_OFS_STATUS) &&
                      wr_data[`DRIT_STAT_MATCH];

  // Hardware standby initialises like power-on reset; no manual reset
  // input exists because it must leave these registers alone.
  always @(posedge aclk) begin
    if (!aresetn || hw_stby) begin
      refresh_counter       <= `DRIT_RST_COUNTER; // RL6
      refresh_compare_value <= `DRIT_RST_COMPARE; // RL8
      prescale_select_field <= `DRIT_RST_SEL;
      refresh_enable_bit    <= 1'b0;
      match_irq_enable      <= 1'b0;
      match_flag            <= 1'b0;
    end else if (ce) begin
      // A software write wins over the count in the same cycle.
      if (wr_byte && (wr_addr == `DRIT_OFS_COUNTER)) begin
        refresh_counter <= wr_data; // RL1
      end else if (match) begin
        refresh_counter <= 8'h00; // RL3
      end else if (tick) begin
        refresh_counter <= refresh_counter + 8'h01; // RL2
      end
      if (wr_byte && (wr_addr == `DRIT_OFS_COMPARE)) begin
        refresh_compare_value <= wr_data; // RL7
      end
      if (wr_byte && (wr_addr == `DRIT_OFS_CONTROL)) begin
        prescale_select_field <=
          wr_data[`DRIT_CTL_SEL_MSB:`DRIT_CTL_SEL_LSB]; // RL2
        refresh_enable_bit    <= wr_data[`DRIT_CTL_RFSH_BIT];
      end
      if (wr_byte && (wr_addr == `DRIT_OFS_MASK)) begin
        match_irq_enable <= wr_data[`DRIT_STAT_MATCH];
      end
      // A match in the clearing cycle keeps the flag set.
      if (match) begin
        match_flag <= 1'b1; // RL3
      end else if (flag_clear) begin
        match_flag <= 1'b0; // RL9
      end
    end
  end

  // ----------------------------------------------------------------------
  // Refresh request and interrupt
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn || hw_stby) begin
      refresh_req     <= 1'b0;
      match_interrupt <= 1'b0;
    end else if (ce) begin
      // Matches while a request waits merge into it.
      if (match && refresh_enable_bit) begin
        refresh_req <= 1'b1; // RL4
      end else if (refresh_ack) begin
        refresh_req <= 1'b0;
      end
      match_interrupt <= (match_flag | match) & match_irq_enable; // RL5
    end
  end

  // ----------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------
  always @* begin
    case (rd_addr)
      `DRIT_OFS_COUNTER: rd_data = refresh_counter;
      `DRIT_OFS_COMPARE: rd_data = refresh_compare_value;
      `DRIT_OFS_CONTROL: rd_data = {4'h0, refresh_enable_bit,
                                    prescale_select_field};
      `DRIT_OFS_STATUS:  rd_data = {7'h00, match_flag};
      `DRIT_OFS_MASK:    rd_data = {7'h00, match_irq_enable};
      default:           rd_data = 8'h00;
    endcase
  end

endmodule // drit_timer

// >>> verification/drit_timer_properties.sv
/*
  Port checker of the refresh timer.
  Assumes a bind to drit_timer, one clock aclk and ce held high.
*/
`timescale 1ns/1ps
module drit_timer_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        hw_standby,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        refresh_req,
  input wire        refresh_ack,
  input wire        match_interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  // The bench keeps the request low before hardware standby.
  property p_req_hold;
    refresh_req && !refresh_ack && !hw_standby |=> refresh_req;
  endproperty
  property p_rst_out;
    aresetn && !$past(aresetn) |->
      !refresh_req && !match_interrupt && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  property p_hw_stby;
    hw_standby [*4] |=> !refresh_req && !match_interrupt;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  property p_r_width;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty

  a_req_hold: assert property (p_req_hold)
    else $error("refresh request dropped before acknowledge");
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not cleared by reset");
  a_hw_stby: assert property (p_hw_stby)
    else $error("outputs active in hardware standby");
  a_b_hold: assert property (p_b_hold)
    else $error("write response not held");
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  a_r_lat: assert property (p_r_lat)
    else $error("read answer late");
  a_b_lat: assert property (p_b_lat)
    else $error("write answer at wrong cycle");
  a_r_width: assert property (p_r_width)
    else $error("read data wider than a byte");

  c_req: cover property ($rose(refresh_req));
  c_irq: cover property ($rose(match_interrupt));
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // drit_timer_checker

// >>> verification/drit_refresh_model.sv
/*
  Refresh cycle logic model: acknowledges a request for one cycle
  after delay cycles. Assumes aclk and the timer's reset.
*/
`timescale 1ns/1ps
module drit_refresh_model (
  // Clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // Handshake
  input  wire       refresh_req,
  input  wire [3:0] delay,
  output reg        refresh_ack
);
  reg [3:0] wait_cnt;

  // A long delay stands for a slow refresh that keeps the timer waiting.
  always @(posedge aclk) begin
    if (!aresetn || !refresh_req || refresh_ack) begin
      wait_cnt    <= 4'h0;
      refresh_ack <= 1'b0;
    end else if (wait_cnt == delay) begin
      refresh_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // drit_refresh_model

// >>> verification/testbench.sv
/*
  Self-checking bench of the refresh timer with one task per scenario.
  Assumes the design, checker and refresh model compiled first.
*/
`timescale 1ns/1ps
`include "drit_defines.vh"
module testbench;
  localparam [7:0] r_cnt = `DRIT_OFS_COUNTER;
  localparam [7:0] r_cmp = `DRIT_OFS_COMPARE;
  localparam [7:0] r_ctl = `DRIT_OFS_CONTROL;
  localparam [7:0] r_st  = `DRIT_OFS_STATUS;
  localparam [7:0] r_msk = `DRIT_OFS_MASK;
  logic        aclk = 0, aresetn = 0, hw_standby = 0, sw_standby = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, val;
  logic [3:0]  wstrb = 0, delay = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic        req, ack, irq;
  int          num_errors = 0, cmp_count = 0, cyc = 0, t0;

  drit_timer u_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .hw_standby(hw_standby), .sw_standby(sw_standby),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .refresh_req(req), .refresh_ack(ack), .match_interrupt(irq));
  drit_refresh_model u_ref (.aclk(aclk), .aresetn(aresetn),
    .refresh_req(req), .delay(delay), .refresh_ack(ack));

  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      num_errors++;
      wrap_up();
    end
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s = 4'hF,
                    input int lag = 0);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    @(posedge aclk);
    while (awvalid && !awready || wvalid && !wready) begin
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      @(posedge aclk);
    end
    awvalid <= 0;
    wvalid <= 0;
    // A late bready lets the checker see the response held.
    repeat (lag) @(posedge aclk);
    bready <= 1;
    @(posedge aclk);
    while (!bvalid) @(posedge aclk);
    resp = bresp;
    bready <= 0;
  endtask
  task automatic rd(input [7:0] a, input int lag = 0);
    araddr <= a;
    arvalid <= 1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 0;
    repeat (lag) @(posedge aclk);
    rready <= 1;
    @(posedge aclk);
    while (!rvalid) @(posedge aclk);
    val = rdata;
    resp = rresp;
    rready <= 0;
  endtask
  task automatic rdchk(input [7:0] a, input [31:0] exp);
    rd(a);
    chk(val, exp);
    chk(resp, `DRIT_RESP_OKAY);
  endtask
  task automatic wait_rise();
    while (req) @(posedge aclk);
    while (!req) @(posedge aclk);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    rdchk(r_cnt, 32'h0);
    rdchk(r_cmp, 32'hFF);
    rdchk(r_st, 32'h0);
    rd(8'h14, 3);
    chk(resp, `DRIT_RESP_SLVERR);
    chk(val, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_regs();
    wr(r_cmp, 32'hFFFFFFA5);
    chk(resp, `DRIT_RESP_OKAY);
    rdchk(r_cmp, 32'hA5);
    wr(r_cnt, 32'h33);
    wr(r_cnt, 32'h77, 4'h0);
    rdchk(r_cnt, 32'h33);
    wr(8'h14, 32'h1, 4'hF, 3);
    chk(resp, `DRIT_RESP_SLVERR);
    $display("test registers done");
  endtask
  task automatic t_match();
    wr(r_cmp, 32'h3);
    wr(r_cnt, 32'h0);
    wr(r_msk, 32'h1);
    wr(r_ctl, 32'h9);
    wait_rise();
    t0 = cyc;
    wait_rise();
    chk(cyc - t0, 8);
    chk(irq, 1);
    wr(r_msk, 32'h0);
    rdchk(r_st, 32'h1);
    chk(irq, 0);
    wr(r_ctl, 32'h8);
    wr(r_st, 32'h1);
    rdchk(r_st, 32'h0);
    $display("test match done");
  endtask
  task automatic t_norfsh();
    int n;
    n = 0;
    wr(r_ctl, 32'h1);
    repeat (40) begin
      @(posedge aclk);
      n += req;
    end
    chk(n, 0);
    wr(r_ctl, 32'h0);
    rd(r_cnt);
    chk(val < 4, 1);
    rdchk(r_st, 32'h1);
    wr(r_st, 32'h1);
    $display("test refresh off done");
  endtask
  task automatic t_sel();
    logic [3:0] taps[7] = '{`DRIT_TAP_1, `DRIT_TAP_2, `DRIT_TAP_3,
      `DRIT_TAP_4, `DRIT_TAP_5, `DRIT_TAP_6, `DRIT_TAP_7};
    wr(r_cmp, 32'h1);
    for (int s = 1; s < 8; s++) begin
      delay <= (s > 2) ? 4'hA : 4'h0;
      wr(r_ctl, 32'h8 | s);
      wait_rise();
      t0 = cyc;
      wait_rise();
      chk(cyc - t0, 2 * (2 << taps[s - 1]));
    end
    wr(r_ctl, 32'h0);
    $display("test prescaler done");
  endtask
  task automatic t_sw();
    logic [31:0] v1;
    wr(r_cmp, 32'hFF);
    wr(r_cnt, 32'h0);
    wr(r_ctl, 32'h1);
    sw_standby <= 1;
    repeat (4) @(posedge aclk);
    rd(r_cnt);
    v1 = val;
    repeat (20) @(posedge aclk);
    rdchk(r_cnt, v1);
    sw_standby <= 0;
    wr(r_ctl, 32'h0);
    $display("test software standby done");
  endtask
  task automatic t_hw();
    wr(r_cmp, 32'h42);
    wr(r_cnt, 32'h11);
    hw_standby <= 1;
    repeat (6) @(posedge aclk);
    hw_standby <= 0;
    repeat (4) @(posedge aclk);
    rdchk(r_cnt, 32'h0);
    rdchk(r_cmp, 32'hFF);
    $display("test hardware standby done");
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_reset();
    t_regs();
    t_match();
    t_norfsh();
    t_sel();
    t_sw();
    t_hw();
    wrap_up();
  end
endmodule // testbench

bind drit_timer drit_timer_checker u_chk (.aclk, .aresetn, .hw_standby,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .refresh_req, .refresh_ack, .match_interrupt);
